//--- core/irq_prio_pkg.sv
// Package: constants and types for the vectored interrupt priority unit
package irq_prio_pkg;
  localparam int NODES = 14;
  localparam int NMI_SRCS = 6;
  localparam int EXT_GRP = 4;
  localparam int T2_GRP = 3;
  localparam int LVL_W = 2;
  localparam int VEC_W = 16;
  localparam int IDX_W = 4;
  localparam logic [15:0] NMI_VECTOR = 16'h0073;
  localparam logic [15:0] NODE_VECTOR_BASE = 16'h0003;
  localparam logic [15:0] NODE_VECTOR_STEP = 16'h0008;
  localparam logic [3:0] T2_NODE = 4'h5;
  localparam logic [3:0] EXT_GRP_NODE = 4'h9;
  localparam logic [1:0] TOP_LEVEL = 2'h3;
  localparam logic [13:0] PEND_RESET = 14'h0000;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  // Active service stack: one bit per maskable level plus one for NMI
  localparam int ACT_W = 5;
  localparam int NMI_ACT_BIT = 4;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_GRANT = 2'b01
  } grant_state_e;
endpackage

//--- core/irq_arbiter.sv
// Arbiter: level then polling order selection among maskable nodes
module irq_arbiter (
  input  wire logic [13:0] req,       // Eligible enabled pending nodes
  input  wire logic [27:0] lvl,       // Two level bits per node
  output logic             found,     // Some node selected
  output logic [3:0]       idx,       // Winning node number
  output logic [1:0]       win_lvl    // Winning node level
);
  always_comb begin
    found   = 1'b0;
    idx     = 4'h0;
    win_lvl = 2'h0;
    // Lower node number is earlier in polling; strictly higher level replaces
    for (int i = 0; i < irq_prio_pkg::NODES; i++) begin
      if (req[i] && (!found || lvl[2*i +: 2] > win_lvl)) begin
        found   = 1'b1;
        idx     = 4'(i);
        win_lvl = lvl[2*i +: 2];
      end
    end
  end
endmodule

//--- core/vectored_interrupt_priority_unit.sv
// Top: vectored interrupt priority unit with NMI and fourteen maskable nodes
// Functional notes
// - One NMI plus fourteen maskable nodes served
// - Fixed vectors: NMI 0073, nodes 0003 step 8
// - Granted node's vector supplied; core branches there
// - Disabled node never forwarded for service
// - Shared vectors keep per-source status flags
// - Timer-two group node five, external 3-6 node nine
// - Maskable nodes take four levels; NMI fixed
// - NMI outranks and preempts all maskable service
// - Level from paired low/high priority bits
// - Only strictly higher level preempts running service
// - Topmost level service is interrupted only by NMI
// - Highest level wins among simultaneous requests
// - Same level resolved by fixed polling order
// - Polling order follows node numbering zero..thirteen
module vectored_interrupt_priority_unit (
  input  wire logic        ref_clk,                     // System clock, 50 MHz
  input  wire logic        rst_b,                       // Synchronous reset, active low
  input  wire logic [11:0] node_src_pulse,              // Single-source node events, nodes 0-4,6-8,10-13 packed
  input  wire logic [2:0]  t2_grp_pulse,                // Timer-two, divider overflow, bus break events
  input  wire logic [3:0]  ext_grp_pulse,               // External request three to six events
  input  wire logic [5:0]  nmi_src_pulse,               // NMI source events
  input  wire logic [13:0] node_enable,                 // Enable bits of both enable registers
  input  wire logic [7:0]  prio_low_bits_a,             // Low level bits, nodes 0-6
  input  wire logic [7:0]  prio_high_bits_a,            // High level bits, nodes 0-6
  input  wire logic [7:0]  prio_low_bits_b,             // Low level bits, nodes 7-13
  input  wire logic [7:0]  prio_high_bits_b,            // High level bits, nodes 7-13
  input  wire logic [5:0]  nmi_control_reg,             // NMI source enables
  input  wire logic [13:0] pend_clear,                  // Software clear of node pending
  input  wire logic [2:0]  t2_grp_flag_clear,           // Software clear of timer-two group flags
  input  wire logic [3:0]  ext_grp_flag_clear,          // Software clear of external group flags
  input  wire logic [5:0]  nmi_flag_clear,              // Software clear of NMI source flags
  input  wire logic        irq_ack,                     // Core takes the offered vector
  input  wire logic        irq_return,                  // Core ends current service routine
  output logic             irq_req,                     // Vector offered to core
  output logic [15:0]      irq_vector,                  // Vector address of offered request
  output logic [13:0]      node_pending,                // Latched node requests
  output logic [2:0]       t2_grp_flags,                // Timer-two group source flags
  output logic [3:0]       ext_grp_flags,               // External group source flags
  output logic [5:0]       nmi_flags,                   // NMI source flags
  output logic [4:0]       active_levels                // Services in progress, bit 4 is NMI
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    irq_prio_pkg::grant_state_e st;
    logic [13:0] pend;
    logic [2:0]  t2f;
    logic [3:0]  extf;
    logic [5:0]  nmif;
    logic [4:0]  act;
    logic        req;
    logic [15:0] vec;
    logic        is_nmi;
    logic [3:0]  idx;
    logic [1:0]  lvl;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  logic [13:0] node_evt;
  logic [27:0] lvl_bus;
  logic [13:0] eligible;
  logic        arb_found;
  logic [3:0]  arb_idx;
  logic [1:0]  arb_lvl;
  logic        nmi_any;

  // ************************************************************
  // Node vector decode
  // ************************************************************
  function automatic logic [15:0] node_vector(input logic [3:0] n);
    node_vector = irq_prio_pkg::NODE_VECTOR_BASE
                + 16'({12'h000, n} * irq_prio_pkg::NODE_VECTOR_STEP);
  endfunction

  // Highest level currently in service, or none
  function automatic logic [2:0] run_level(input logic [4:0] a);
    run_level = 3'h0;
    for (int k = 0; k < 4; k++) begin
      if (a[k]) begin
        run_level = 3'(k + 1);
      end
    end
  endfunction

  // ************************************************************
  // Event and level mapping
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < irq_prio_pkg::NODES; g++) begin : g_node
      // Level from one bit of each paired register
      if (g < 7) begin : g_a
        assign lvl_bus[2*g +: 2] = {prio_high_bits_a[g], prio_low_bits_a[g]};
      end else begin : g_b
        assign lvl_bus[2*g +: 2] = {prio_high_bits_b[g-7], prio_low_bits_b[g-7]};
      end
      if (g == 5) begin : g_t2
        assign node_evt[g] = |t2_grp_pulse;
      end else if (g == 9) begin : g_ext
        assign node_evt[g] = |ext_grp_pulse;
      end else if (g < 5) begin : g_lo
        assign node_evt[g] = node_src_pulse[g];
      end else if (g < 9) begin : g_mid
        assign node_evt[g] = node_src_pulse[g-1];
      end else begin : g_hi
        assign node_evt[g] = node_src_pulse[g-2];
      end
    end
  endgenerate

  // ************************************************************
  // Eligibility and arbitration
  // ************************************************************
  always_comb begin
    for (int i = 0; i < irq_prio_pkg::NODES; i++) begin
      // Only strictly above highest running level, never over top or NMI
      eligible[i] = state_r.pend[i] && node_enable[i]
                  && ({1'b0, lvl_bus[2*i +: 2]} >= run_level(state_r.act))
                  && !state_r.act[irq_prio_pkg::NMI_ACT_BIT];
    end
  end

  // Level first, then polling order
  irq_arbiter u_arb (
    .req     (eligible),
    .lvl     (lvl_bus),
    .found   (arb_found),
    .idx     (arb_idx),
    .win_lvl (arb_lvl)
  );

  assign nmi_any = |(state_r.nmif & nmi_control_reg);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    // Set wins over clear on every flag
    state_nxt.t2f  = (state_r.t2f & ~t2_grp_flag_clear) | t2_grp_pulse;
    state_nxt.extf = (state_r.extf & ~ext_grp_flag_clear) | ext_grp_pulse;
    state_nxt.nmif = (state_r.nmif & ~nmi_flag_clear) | nmi_src_pulse;
    state_nxt.pend = (state_r.pend & ~pend_clear) | node_evt;
    if (irq_return && state_r.st == irq_prio_pkg::ST_IDLE) begin
      // Close the innermost running service
      if (state_r.act[irq_prio_pkg::NMI_ACT_BIT]) begin
        state_nxt.act[irq_prio_pkg::NMI_ACT_BIT] = 1'b0;
      end else begin
        for (int k = 3; k >= 0; k--) begin
          if (state_r.act[k] && run_level(state_r.act) == 3'(k + 1)) begin
            state_nxt.act[k] = 1'b0;
          end
        end
      end
    end
    unique case (state_r.st)
      irq_prio_pkg::ST_IDLE: begin
        if (!irq_return) begin
          if (nmi_any && !state_r.act[irq_prio_pkg::NMI_ACT_BIT]) begin
            state_nxt.st     = irq_prio_pkg::ST_GRANT;
            state_nxt.req    = 1'b1;
            state_nxt.is_nmi = 1'b1;
            state_nxt.vec    = irq_prio_pkg::NMI_VECTOR;
          end else if (arb_found) begin
            state_nxt.st     = irq_prio_pkg::ST_GRANT;
            state_nxt.req    = 1'b1;
            state_nxt.is_nmi = 1'b0;
            state_nxt.idx    = arb_idx;
            state_nxt.lvl    = arb_lvl;
            state_nxt.vec    = node_vector(arb_idx);
          end
        end
      end
      irq_prio_pkg::ST_GRANT: begin
        if (irq_ack) begin
          state_nxt.st  = irq_prio_pkg::ST_IDLE;
          state_nxt.req = 1'b0;
          if (state_r.is_nmi) begin
            state_nxt.act[irq_prio_pkg::NMI_ACT_BIT] = 1'b1;
            // Take clears enabled source flags; a new event still sets
            state_nxt.nmif = (state_r.nmif & ~nmi_control_reg & ~nmi_flag_clear) | nmi_src_pulse;
          end else begin
            state_nxt.act[state_r.lvl] = 1'b1;
            // Serviced node drops pending; shared flags stay for software
            state_nxt.pend[state_r.idx] = node_evt[state_r.idx];
          end
        end
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= '{st: irq_prio_pkg::ST_IDLE, pend: irq_prio_pkg::PEND_RESET,
                   vec: irq_prio_pkg::VEC_RESET, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign irq_req       = state_r.req;
  assign irq_vector    = state_r.vec;
  assign node_pending  = state_r.pend;
  assign t2_grp_flags  = state_r.t2f;
  assign ext_grp_flags = state_r.extf;
  assign nmi_flags     = state_r.nmif;
  assign active_levels = state_r.act;
endmodule

//--- sim/irq_prio_monitor.sv
// Checker of the grant protocol of the interrupt priority unit
module irq_prio_monitor (
  input wire logic        ref_clk,         // Clock
  input wire logic        rst_b,           // Reset
  input wire logic [13:0] node_enable,     // Node enables
  input wire logic [5:0]  nmi_control_reg, // NMI enables
  input wire logic        irq_ack,         // Core take
  input wire logic        irq_return,      // Routine end
  input wire logic        irq_req,         // Offer
  input wire logic [15:0] irq_vector,      // Offered vector
  input wire logic [5:0]  nmi_flags,       // NMI flags
  input wire logic [4:0]  active_levels    // Services open
);
  logic [13:0] enable_seen_r;
  logic        nmi_src_seen_r;
  // Grant inputs as seen at the deciding edge
  always_ff @(posedge ref_clk) begin
    enable_seen_r  <= node_enable;
    nmi_src_seen_r <= |(nmi_flags & nmi_control_reg);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_ack; irq_req && irq_ack; endsequence
  property p_hold; irq_req && !irq_ack |=> irq_req && $stable(irq_vector); endproperty
  a_hold: assert property (p_hold) else $error("offer withdrawn");
  property p_drop; s_ack |=> !irq_req; endproperty
  a_drop: assert property (p_drop) else $error("offer kept after take");
  property p_vec;
    irq_req |-> irq_vector == 16'h0073 || (irq_vector[2:0] == 3'h3 && irq_vector <= 16'h006b);
  endproperty
  a_vec: assert property (p_vec) else $error("vector off table");
  property p_dis;
    $rose(irq_req) && irq_vector != 16'h0073 |-> enable_seen_r[irq_vector[6:3]];
  endproperty
  a_dis: assert property (p_dis) else $error("disabled node granted");
  property p_nmi_act; s_ack ##0 irq_vector == 16'h0073 |=> active_levels[4]; endproperty
  a_nmi_act: assert property (p_nmi_act) else $error("NMI service not opened");
  property p_nmi_blk; active_levels[4] && !irq_req |=> !irq_req; endproperty
  a_nmi_blk: assert property (p_nmi_blk) else $error("grant during NMI service");
  property p_top;
    active_levels[3] && !irq_req |=> !irq_req || irq_vector == 16'h0073;
  endproperty
  a_top: assert property (p_top) else $error("top level service preempted");
  property p_ret;
    irq_return && !irq_req && |active_levels
      |=> $countones(active_levels) == $countones($past(active_levels)) - 1;
  endproperty
  a_ret: assert property (p_ret) else $error("return closed no service");
  property p_nmi_src;
    $rose(irq_req) && irq_vector == 16'h0073 |-> nmi_src_seen_r;
  endproperty
  a_nmi_src: assert property (p_nmi_src) else $error("NMI without enabled source");
endmodule
bind vectored_interrupt_priority_unit irq_prio_monitor u_irq_prio_monitor (.ref_clk, .rst_b,
  .node_enable, .nmi_control_reg, .irq_ack, .irq_return, .irq_req, .irq_vector, .nmi_flags,
  .active_levels);

//--- sim/core_model.sv
// Core model: takes offered vectors after a set wait
module core_model (
  input  wire logic        ref_clk,    // Clock
  input  wire logic        irq_req,    // Offer
  input  wire logic [15:0] irq_vector, // Offered vector
  input  wire logic [3:0]  ack_delay,  // Wait before take
  output logic             irq_ack,    // Take pulse
  output logic [15:0]      last_vec,   // Branch target
  output int               acks        // Vectors taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r = 4'h0;
  initial irq_ack = 1'b0;
  initial acks = 0;
  always @(negedge ref_clk) begin
    irq_ack <= 1'b0;
    if (!irq_req || irq_ack) wait_r <= 4'h0;
    else if (wait_r < ack_delay) wait_r <= wait_r + 4'h1;
    else begin
      irq_ack <= 1'b1;
      last_vec <= irq_vector;
      acks <= acks + 1;
    end
  end
endmodule

//--- sim/tb_top.sv
// Testbench of the vectored interrupt priority unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0, rst_b = 1'b0, irq_return = 1'b0, irq_req, irq_ack;
  logic [3:0]  ack_delay = 4'h0;
  logic [11:0] node_src_pulse = 12'h000;
  logic [2:0]  t2_grp_pulse = 3'h0, t2_grp_flag_clear = 3'h0, t2_grp_flags;
  logic [3:0]  ext_grp_pulse = 4'h0, ext_grp_flag_clear = 4'h0, ext_grp_flags;
  logic [5:0]  nmi_src_pulse = 6'h00, nmi_control_reg = 6'h3f, nmi_flag_clear = 6'h00, nmi_flags;
  logic [13:0] node_enable = 14'h3fff, pend_clear = 14'h0000, node_pending;
  logic [7:0]  prio_low_bits_a = 8'h00, prio_high_bits_a = 8'h00;
  logic [7:0]  prio_low_bits_b = 8'h00, prio_high_bits_b = 8'h00;
  logic [15:0] irq_vector, last_vec;
  logic [4:0]  active_levels;
  int          errors = 0, check_count = 0, acks;
  always #10 ref_clk = ~ref_clk;
  core_model u_core_model (.ref_clk, .irq_req, .irq_vector, .ack_delay, .irq_ack, .last_vec,
    .acks);
  vectored_interrupt_priority_unit u_vectored_interrupt_priority_unit (.ref_clk, .rst_b,
    .node_src_pulse, .t2_grp_pulse, .ext_grp_pulse, .nmi_src_pulse, .node_enable,
    .prio_low_bits_a, .prio_high_bits_a, .prio_low_bits_b, .prio_high_bits_b, .nmi_control_reg,
    .pend_clear, .t2_grp_flag_clear, .ext_grp_flag_clear, .nmi_flag_clear, .irq_ack,
    .irq_return, .irq_req, .irq_vector, .node_pending, .t2_grp_flags, .ext_grp_flags,
    .nmi_flags, .active_levels);
  task automatic chk(string name, logic [15:0] exp, logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bit 14 of the mask is the watchdog NMI source
  task automatic fire(logic [14:0] m);
    @(negedge ref_clk);
    for (int n = 0; n < 14; n++) begin
      if (m[n] && n == 5) t2_grp_pulse[2] = 1'b1;
      else if (m[n] && n == 9) ext_grp_pulse[3] = 1'b1;
      else if (m[n]) node_src_pulse[n - (n > 5) - (n > 9)] = 1'b1;
    end
    nmi_src_pulse[0] = m[14];
    @(negedge ref_clk);
    {node_src_pulse, t2_grp_pulse, ext_grp_pulse, nmi_src_pulse} = '0;
  endtask
  task automatic got(logic [15:0] exp);
    int c;
    c = acks;
    for (int i = 0; i < 40 && acks == c; i++) @(posedge ref_clk);
    chk("vector", exp, (acks == c) ? 16'hxxxx : last_vec);
  endtask
  task automatic quiet();
    int c;
    c = acks;
    repeat (10) @(posedge ref_clk);
    chk("grant count", 16'(c), 16'(acks));
  endtask
  task automatic ret();
    @(negedge ref_clk) irq_return = 1'b1;
    @(negedge ref_clk) irq_return = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("idle", 16'h0000, {1'b0, irq_req, node_pending});
    for (int n = 0; n < 14; n++) begin
      ack_delay = 4'(n % 3);
      fire(15'h0001 << n);
      if (n == 5) chk("t2 flags", 16'h0004, {13'h0, t2_grp_flags});
      if (n == 9) chk("ext flags", 16'h0008, {12'h0, ext_grp_flags});
      got(16'h0003 + 16'(8 * n));
      ret();
    end
    node_enable[0] = 1'b0;
    fire(15'h0001);
    quiet();
    chk("held", 16'h0001, {15'h0, node_pending[0]});
    @(negedge ref_clk) node_enable[0] = 1'b1;
    got(16'h0003);
    ret();
    fire(15'h2004);
    got(16'h0013);
    quiet();
    ret();
    got(16'h006b);
    ret();
    prio_high_bits_b[5] = 1'b1;
    fire(15'h1002);
    got(16'h0063);
    ret();
    got(16'h000b);
    ret();
    prio_low_bits_a[3] = 1'b1;
    prio_high_bits_a[3] = 1'b1;
    fire(15'h0008);
    got(16'h001b);
    fire(15'h1000);
    quiet();
    fire(15'h4000);
    got(16'h0073);
    @(negedge ref_clk);
    chk("active", 16'h0018, {11'h0, active_levels});
    chk("nmi flags", 16'h0000, {10'h0, nmi_flags});
    ret();
    ret();
    got(16'h0063);
    ret();
    node_enable[1] = 1'b0;
    fire(15'h0002);
    @(negedge ref_clk) pend_clear[1] = 1'b1;
    @(negedge ref_clk) pend_clear[1] = 1'b0;
    chk("cleared", 16'h0000, {2'h0, node_pending});
    node_enable[1] = 1'b1;
    quiet();
    nmi_control_reg[0] = 1'b0;
    fire(15'h4000);
    quiet();
    chk("flags held", 16'h00c8, {3'h0, nmi_flags, t2_grp_flags, ext_grp_flags});
    @(negedge ref_clk) {nmi_flag_clear, t2_grp_flag_clear, ext_grp_flag_clear} = 13'h00c8;
    @(negedge ref_clk) {nmi_flag_clear, t2_grp_flag_clear, ext_grp_flag_clear} = 13'h0000;
    chk("flags cleared", 16'h0000, {3'h0, nmi_flags, t2_grp_flags, ext_grp_flags});
    print_verdict();
  end
endmodule
